/* rtl/ubsf_consts.vh */
// Constants for the baud timing and sampling block
`ifndef UBSF_CONSTS_VH
`define UBSF_CONSTS_VH
`define UBSF_TCS_16      3'h0
`define UBSF_TCS_16_17   3'h1
`define UBSF_TCS_15      3'h2
`define UBSF_TCS_15_16   3'h3
`define UBSF_TCS_17      3'h4
`define UBSF_SAMPLE_HI   5'h08
`define UBSF_SAMPLE_MID  5'h07
`define UBSF_SAMPLE_LO   5'h06
`define UBSF_DATA_BITS   4'h8
`define UBSF_NF_OFF      2'h0
`define UBSF_NBASE_W     4
`endif

/* rtl/ubsf_prescaler.v */
// Base clock selection and oversample tick prescaler
`timescale 1ns/10ps
`default_nettype none
module ubsf_prescaler #(
   parameter DIV_W = 8,
   parameter NSEL  = 4
) (
   input  wire             i_mclk,
   input  wire             i_arst_n,
   input  wire [NSEL-1:0]  i_base_ce,
   input  wire [1:0]       i_base_clock_select,
   input  wire [DIV_W-1:0] i_baud_divisor,
   output reg              o_base_ce,
   output reg              o_tick
);
   reg [DIV_W-1:0] cnt_reg;
   wire            ce = i_base_ce[i_base_clock_select];

   // Count divisor+1 base pulses per tick; base pulse delayed to align with tick
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt_reg   <= {DIV_W{1'b0}};
         o_tick    <= 1'b0;
         o_base_ce <= 1'b0;
      end
      else
      begin
         o_base_ce <= ce;
         o_tick    <= 1'b0;
         if (ce)
         begin
            if (cnt_reg >= i_baud_divisor)
            begin
               cnt_reg <= {DIV_W{1'b0}};
               o_tick  <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule // ubsf_prescaler
`default_nettype wire

/* rtl/ubsf_noise_filter.v */
// Receive input noise filter counted in base clock pulses
`include "ubsf_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ubsf_noise_filter #(
   parameter DIV_W = 8
) (
   input  wire             i_mclk,
   input  wire             i_arst_n,
   input  wire             i_base_ce,
   input  wire [1:0]       i_rx_noise_filter_select,
   input  wire [DIV_W-1:0] i_baud_divisor,
   input  wire             i_serial_in,
   output reg              o_serial_filt
);
   reg  [DIV_W+3:0] run_reg;
   wire [DIV_W+3:0] unit  = {4'h0, i_baud_divisor} + 1'b1;
   // A level must persist twice the rejection time before it is taken
   wire [DIV_W+3:0] need  = (i_rx_noise_filter_select == 2'h1) ? (unit << 1) :
                            (i_rx_noise_filter_select == 2'h2) ? (unit << 2) : (unit << 3);

   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         run_reg       <= {(DIV_W+4){1'b0}};
         o_serial_filt <= 1'b1;
      end
      else if (i_rx_noise_filter_select == `UBSF_NF_OFF)
      begin
         run_reg       <= {(DIV_W+4){1'b0}};
         o_serial_filt <= i_serial_in;
      end
      else if (i_serial_in == o_serial_filt)
         run_reg <= {(DIV_W+4){1'b0}};   // Glitch ended: restart the count
      else if (i_base_ce)
      begin
         if (run_reg + 1'b1 >= need)
         begin
            o_serial_filt <= i_serial_in;
            run_reg       <= {(DIV_W+4){1'b0}};
         end
         else
            run_reg <= run_reg + 1'b1;
      end
   end
endmodule // ubsf_noise_filter
`default_nettype wire

/* rtl/ubsf_core.v */
// Baud timing, transmit framing and receive sampling core of a serial port
// Operation
// - Each bit lasts 15 to 17 oversample ticks per tick-count select
// - One tick per divisor+1 pulses of the selected base clock
// - Codes 001/011 alternate 16/17 or 15/16, start bit smaller
// - Codes 000/010/100 give fixed 16, 15 or 17 ticks
// - Receiver starts counting on falling edge of serial input
// - Tick counter counts down from ticks-1 to zero per bit
// - Sample at counts 8, 7 and 6 whatever the bit width
// - Bit value is majority of the three samples
// - Start bit voted high abandons reception until next falling edge
// - Filter select 00 off, else reject 1, 2 or 4 units
// - Filtered pulses must last 2, 4 or 8 units to pass
// - Tick pattern applies equally to transmit and receive
// - Frame: low start, eight data, optional parity, one or two stops
// - Parity enable, parity sense and stop count are selectable
`include "ubsf_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ubsf_core #(
   parameter DIV_W = 8,
   parameter NSEL  = `UBSF_NBASE_W
) (
   input  wire             i_mclk,
   input  wire             i_arst_n,
   input  wire [NSEL-1:0]  i_base_ce,
   input  wire [1:0]       i_base_clock_select,
   input  wire [DIV_W-1:0] i_baud_divisor,
   input  wire [2:0]       i_tick_count_select,
   input  wire [1:0]       i_rx_noise_filter_select,
   input  wire             i_parity_enable,
   input  wire             i_parity_odd,
   input  wire             i_stop_bits_select,
   input  wire             i_rx_enable,
   input  wire             i_tx_enable,
   input  wire             i_tx_start,
   input  wire [7:0]       i_tx_data,
   input  wire             i_serial_in,
   output reg              o_serial_out,
   output reg              o_tx_busy,
   output reg              o_tx_done,
   output reg              o_rx_busy,
   output reg              o_rx_bit_valid,
   output reg              o_rx_bit,
   output reg              o_rx_done,
   output reg [7:0]        o_rx_data,
   output reg              o_rx_parity_err,
   output reg              o_rx_frame_err,
   output reg              o_rx_start_abort
);
   // Both directions use the same two-state encoding
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;

   // Tick enable, delayed base pulse and filtered line
   wire tick;
   wire base_ce;
   wire rx_filt;

   // Tick enable from the selected base clock; it runs free, frames do not re-phase it
   ubsf_prescaler #(.DIV_W(DIV_W), .NSEL(NSEL)) u_presc (
      .i_mclk              (i_mclk),
      .i_arst_n            (i_arst_n),
      .i_base_ce           (i_base_ce),
      .i_base_clock_select (i_base_clock_select),
      .i_baud_divisor      (i_baud_divisor),
      .o_base_ce           (base_ce),
      .o_tick              (tick)
   );

   // Filter output feeds every receive decision, so unless select is 00 glitches never reach the voter
   ubsf_noise_filter #(.DIV_W(DIV_W)) u_filt (
      .i_mclk                   (i_mclk),
      .i_arst_n                 (i_arst_n),
      .i_base_ce                (base_ce),
      .i_rx_noise_filter_select (i_rx_noise_filter_select),
      .i_baud_divisor           (i_baud_divisor),
      .i_serial_in              (i_serial_in),
      .o_serial_filt            (rx_filt)
   );

   // Last count (ticks-1) of a bit; odd index gets the longer of an alternating pair
   function [4:0] last_cnt;
      input [2:0] sel;
      input       odd;
      begin
         case (sel)
            `UBSF_TCS_16:    last_cnt = 5'h0f;
            `UBSF_TCS_16_17: last_cnt = odd ? 5'h10 : 5'h0f;
            `UBSF_TCS_15:    last_cnt = 5'h0e;
            `UBSF_TCS_15_16: last_cnt = odd ? 5'h0f : 5'h0e;
            `UBSF_TCS_17:    last_cnt = 5'h10;
            default:         last_cnt = 5'h0f;
         endcase
      end
   endfunction

   // Frame length in bits: start + data + parity + stops
   wire [3:0] frame_bits = 4'h1 + `UBSF_DATA_BITS + {3'h0, i_parity_enable}
                           + {3'h0, i_stop_bits_select} + 4'h1;
   // Index of the last stop bit; both directions end on it
   wire [3:0] last_idx   = frame_bits - 4'h1;

   // Transmit state, bit count, bit index and remaining bits
   reg [1:0]  tx_st_reg;
   reg [4:0]  tx_cnt_reg;
   reg [3:0]  tx_idx_reg;
   reg [11:0] tx_sh_reg;
   wire       tx_par  = ^i_tx_data ^ i_parity_odd;
   // Last stop bit in flight; compared with >= so a mid-frame format change cannot run past it
   wire       tx_last = (tx_idx_reg >= last_idx);

   // Shift register holds the remaining bits; stop bits fill from the top
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tx_st_reg    <= ST_IDLE;
         tx_cnt_reg   <= 5'h00;
         tx_idx_reg   <= 4'h0;
         tx_sh_reg    <= 12'hfff;
         o_serial_out <= 1'b1;
         o_tx_busy    <= 1'b0;
         o_tx_done    <= 1'b0;
      end
      else
      begin
         o_tx_done <= 1'b0;
         case (tx_st_reg)
            ST_IDLE:
            begin
               // Line idles high; a request launches the start bit at once
               o_serial_out <= 1'b1;
               if (i_tx_enable && i_tx_start)
               begin
                  tx_st_reg    <= ST_RUN;
                  o_tx_busy    <= 1'b1;
                  tx_idx_reg   <= 4'h0;
                  tx_cnt_reg   <= last_cnt(i_tick_count_select, 1'b0);
                  o_serial_out <= 1'b0;
                  tx_sh_reg    <= i_parity_enable ? {2'h3, tx_par, i_tx_data, 1'b0}
                                                  : {3'h7, i_tx_data, 1'b0};
               end
            end
            ST_RUN:
            begin
               if (tick)
               begin
                  // Count down; the line moves only on the tick that finds zero
                  if (tx_cnt_reg != 5'h00)
                     tx_cnt_reg <= tx_cnt_reg - 1'b1;
                  else if (tx_last)
                  begin
                     tx_st_reg    <= ST_IDLE;
                     o_tx_busy    <= 1'b0;
                     o_tx_done    <= 1'b1;
                     o_serial_out <= 1'b1;
                  end
                  else
                  begin
                     // Next bit takes the other width of an alternating pair
                     tx_idx_reg   <= tx_idx_reg + 1'b1;
                     tx_cnt_reg   <= last_cnt(i_tick_count_select, ~tx_idx_reg[0]);
                     tx_sh_reg    <= {1'b1, tx_sh_reg[11:1]};
                     o_serial_out <= tx_sh_reg[1];
                  end
               end
            end
            default:
               tx_st_reg <= ST_IDLE;
         endcase
      end
   end

   // Receive state, counters, vote samples, edge history and frame accumulators
   reg [1:0] rx_st_reg;
   reg [4:0] rx_cnt_reg;
   reg [3:0] rx_idx_reg;
   reg [1:0] smp_reg;
   reg       rx_prev_reg;
   reg [7:0] rx_sh_reg;
   reg       rx_par_reg;
   reg       rx_ferr_reg;
   wire      fall = rx_prev_reg & ~rx_filt;
   // Majority of two stored samples and the current one
   wire      vote = (smp_reg[0] & smp_reg[1]) | (rx_filt & (smp_reg[0] | smp_reg[1]));
   // Position of the bit in flight within the frame
   wire      at_start = (rx_idx_reg == 4'h0);
   wire      at_data  = !at_start && (rx_idx_reg <= `UBSF_DATA_BITS);
   wire      at_par   = i_parity_enable && (rx_idx_reg == 4'h9);
   wire      at_stop  = (rx_idx_reg > `UBSF_DATA_BITS) && !at_par;
   wire      at_last  = at_stop && (rx_idx_reg >= last_idx);

   // Receive sequencer; a start edge is seen up to one tick late as ticks run free
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rx_st_reg        <= ST_IDLE;
         rx_cnt_reg       <= 5'h00;
         rx_idx_reg       <= 4'h0;
         smp_reg          <= 2'h3;
         rx_prev_reg      <= 1'b1;
         rx_sh_reg        <= 8'h00;
         rx_par_reg       <= 1'b0;
         rx_ferr_reg      <= 1'b0;
         o_rx_busy        <= 1'b0;
         o_rx_bit_valid   <= 1'b0;
         o_rx_bit         <= 1'b1;
         o_rx_done        <= 1'b0;
         o_rx_data        <= 8'h00;
         o_rx_parity_err  <= 1'b0;
         o_rx_frame_err   <= 1'b0;
         o_rx_start_abort <= 1'b0;
      end
      else
      begin
         rx_prev_reg      <= rx_filt;
         o_rx_bit_valid   <= 1'b0;
         o_rx_done        <= 1'b0;
         o_rx_start_abort <= 1'b0;
         case (rx_st_reg)
            ST_IDLE:
            begin
               // Wait for a falling edge of the filtered line
               if (i_rx_enable && fall)
               begin
                  rx_st_reg   <= ST_RUN;
                  o_rx_busy   <= 1'b1;
                  rx_idx_reg  <= 4'h0;
                  rx_cnt_reg  <= last_cnt(i_tick_count_select, 1'b0);
                  rx_par_reg  <= i_parity_odd;
                  rx_ferr_reg <= 1'b0;
               end
            end
            ST_RUN:
            begin
               // Disabling the receiver drops a frame at once
               if (!i_rx_enable)
               begin
                  rx_st_reg <= ST_IDLE;
                  o_rx_busy <= 1'b0;
               end
               else if (tick)
               begin
                  // Fixed window at counts 8..6 regardless of bit width
                  if (rx_cnt_reg == `UBSF_SAMPLE_HI)
                     smp_reg[0] <= rx_filt;
                  if (rx_cnt_reg == `UBSF_SAMPLE_MID)
                     smp_reg[1] <= rx_filt;
                  if (rx_cnt_reg == `UBSF_SAMPLE_LO)
                  begin
                     o_rx_bit_valid <= 1'b1;
                     o_rx_bit       <= vote;
                     // Route the vote by the position of the bit
                     if (at_start && vote)
                     begin
                        rx_st_reg        <= ST_IDLE;
                        o_rx_busy        <= 1'b0;
                        o_rx_start_abort <= 1'b1;
                     end
                     else if (at_data)
                     begin
                        rx_sh_reg  <= {vote, rx_sh_reg[7:1]};
                        rx_par_reg <= rx_par_reg ^ vote;
                     end
                     else if (at_par)
                        rx_par_reg <= rx_par_reg ^ vote;
                     else if (at_stop && !vote)
                        rx_ferr_reg <= 1'b1;
                     // Last stop bit is voted: finish now so a new start is not missed
                     if (at_last)
                     begin
                        rx_st_reg       <= ST_IDLE;
                        o_rx_busy       <= 1'b0;
                        o_rx_done       <= 1'b1;
                        o_rx_data       <= rx_sh_reg;
                        o_rx_parity_err <= i_parity_enable & rx_par_reg;
                        o_rx_frame_err  <= rx_ferr_reg | ~vote;
                     end
                  end
                  // Count down; at zero the next bit starts with its own width
                  if (rx_cnt_reg != 5'h00)
                     rx_cnt_reg <= rx_cnt_reg - 1'b1;
                  else
                  begin
                     rx_idx_reg <= rx_idx_reg + 1'b1;
                     rx_cnt_reg <= last_cnt(i_tick_count_select, ~rx_idx_reg[0]);
                  end
               end
            end
            default:
               rx_st_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // ubsf_core
`default_nettype wire

/* bench/ubsf_monitor.sv */
// Port checker for the baud timing and sampling core
`timescale 1ns/10ps
`default_nettype none
module ubsf_monitor (
   input wire logic       i_mclk,
   input wire logic       i_arst_n,
   input wire logic [1:0] i_rx_noise_filter_select,
   input wire logic       i_rx_enable,
   input wire logic       i_tx_enable,
   input wire logic       i_tx_start,
   input wire logic       i_serial_in,
   input wire logic       o_serial_out,
   input wire logic       o_tx_busy,
   input wire logic       o_tx_done,
   input wire logic       o_rx_busy,
   input wire logic       o_rx_bit_valid,
   input wire logic       o_rx_done,
   input wire logic       o_rx_start_abort
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // Bits last at least 15 ticks, so the serial out level and the vote and rx done pulses may not repeat within 8 cycles
   a_tx_idle_high: assert property (!o_tx_busy |-> o_serial_out)
      else $error("line low while idle");
   a_tx_start_low: assert property (!o_tx_busy && i_tx_enable && i_tx_start |=> !o_serial_out && o_tx_busy)
      else $error("start bit missing");
   a_tx_bit_hold: assert property ($changed(o_serial_out) |=> $stable(o_serial_out) [*8])
      else $error("bit too short");
   a_tx_done_stop: assert property (o_tx_done |-> o_serial_out && $past(o_serial_out, 8))
      else $error("frame ended off a stop");
   a_rx_bit_pulse: assert property (o_rx_bit_valid |=> !o_rx_bit_valid [*8])
      else $error("votes too close");
   a_rx_done_once: assert property (o_rx_done |=> !o_rx_done [*8])
      else $error("done repeated");
   a_rx_abort_idle: assert property (o_rx_start_abort |-> ##[0:2] !o_rx_busy)
      else $error("receiver kept going");
   a_rx_start_edge: assert property ($rose(o_rx_busy) && i_rx_noise_filter_select == 2'h0
      |-> !i_serial_in || !$past(i_serial_in) || !$past(i_serial_in, 2))
      else $error("start without a low line");
   a_rx_enable_off: assert property (!i_rx_enable |-> ##[0:2] !o_rx_busy)
      else $error("busy while disabled");
   a_rx_glitch_drop: assert property (!o_rx_busy && i_rx_noise_filter_select != 2'h0 && $past(i_serial_in, 2)
      && !$past(i_serial_in) && i_serial_in |-> !o_rx_busy [*6])
      else $error("glitch started a frame");
   c_rx_done: cover property (o_rx_done);
   c_rx_abort: cover property (o_rx_start_abort);
   c_tx_done: cover property (o_tx_done);
   c_rx_filt: cover property (o_rx_busy && i_rx_noise_filter_select == 2'h3);
endmodule // ubsf_monitor
bind ubsf_core ubsf_monitor i_mon (.i_mclk, .i_arst_n, .i_rx_noise_filter_select, .i_rx_enable, .i_tx_enable,
   .i_tx_start, .i_serial_in, .o_serial_out, .o_tx_busy, .o_tx_done, .o_rx_busy, .o_rx_bit_valid, .o_rx_done,
   .o_rx_start_abort);
`default_nettype wire

/* bench/ubsf_peer.sv */
// Remote serial transceiver model for the line
`timescale 1ns/10ps
`default_nettype none
module ubsf_peer (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_cpt,
   input  wire logic [2:0] i_tcs,
   input  wire logic       i_pe,
   input  wire logic       i_odd,
   input  wire logic       i_stb,
   input  wire logic       i_line,
   output var  logic       o_line
);
   initial o_line = 1'b1;
   // Ticks in bit b, the start bit being bit zero
   function automatic int tk(input logic [2:0] s, input int b);
      case (s)
         3'h1: tk = 16 + b % 2;
         3'h2: tk = 15;
         3'h3: tk = 15 + b % 2;
         3'h4: tk = 17;
         default: tk = 16;
      endcase
   endfunction
   // Whole frame; bp flips the parity, bs pulls the first stop low
   task send(input logic [7:0] d, input logic bp, input logic bs);
      logic [11:0] f;
      int          n, b;
      begin
         f = {3'h7, ^d ^ i_odd ^ bp, d, 1'b0};
         n = 9 + i_pe;
         f[n] = ~bs;
         for (b = 0; b <= n + i_stb; b++)
         begin
            o_line = f[b];
            repeat (tk(i_tcs, b) * i_cpt) @(negedge i_clk);
         end
         o_line = 1'b1;
      end
   endtask
   // Low pulse of n cycles on an otherwise idle line
   task glitch(input int n);
      begin
         o_line = 1'b0;
         repeat (n) @(negedge i_clk);
         o_line = 1'b1;
      end
   endtask
   // Data must start 1,0,1 so that bits 1 and 2 are timed edge to edge; the start bit has a free phase
   task recv(output logic [7:0] d, output int w1, output int w2);
      int i, b, t;
      begin
         d = 8'h01;
         for (i = 0; i < 9999 && i_line; i++) @(negedge i_clk);
         for (i = 0; i < 999 && !i_line; i++) @(negedge i_clk);
         for (w1 = 0; w1 < 999 && i_line; w1++) @(negedge i_clk);
         for (w2 = 0; w2 < 999 && !i_line; w2++) @(negedge i_clk);
         for (b = 3; b < 9; b++)
         begin
            t = tk(i_tcs, b) * i_cpt;
            repeat (t / 2) @(negedge i_clk);
            d[b - 1] = i_line;
            repeat (t - t / 2) @(negedge i_clk);
         end
      end
   endtask
endmodule // ubsf_peer
`default_nettype wire

/* bench/ubsf_core_bench.sv */
// Self-checking bench for the baud timing and sampling core
`timescale 1ns/10ps
`default_nettype none
module ubsf_core_bench;
   logic       i_mclk = 1'b0, i_arst_n = 1'b0, i_tx_start = 1'b0, i_rx_enable = 1'b0, i_tx_enable = 1'b1;
   logic       i_parity_enable = 1'b0, i_parity_odd = 1'b0, i_stop_bits_select = 1'b0;
   logic [3:0] i_base_ce = 4'h1;
   logic [1:0] i_base_clock_select = 2'h0, i_rx_noise_filter_select = 2'h0;
   logic [2:0] i_tick_count_select = 3'h0;
   logic [7:0] i_baud_divisor = 8'h01, i_tx_data = 8'h00, cpt = 8'h02, rd;
   wire        i_serial_in, o_serial_out, o_tx_busy, o_tx_done, o_rx_busy, o_rx_bit_valid, o_rx_bit, o_rx_done;
   wire        o_rx_parity_err, o_rx_frame_err, o_rx_start_abort;
   wire  [7:0] o_rx_data;
   int         num_errors = 0, tests_run = 0, ndone = 0, nab = 0, ph = 0, w1, w2, i, k;
   ubsf_core i_dut (.i_mclk, .i_arst_n, .i_base_ce, .i_base_clock_select, .i_baud_divisor, .i_tick_count_select,
      .i_rx_noise_filter_select, .i_parity_enable, .i_parity_odd, .i_stop_bits_select, .i_rx_enable, .i_tx_enable,
      .i_tx_start, .i_tx_data, .i_serial_in, .o_serial_out, .o_tx_busy, .o_tx_done, .o_rx_busy, .o_rx_bit_valid,
      .o_rx_bit, .o_rx_done, .o_rx_data, .o_rx_parity_err, .o_rx_frame_err, .o_rx_start_abort);
   ubsf_peer i_peer (.i_clk(i_mclk), .i_cpt(cpt), .i_tcs(i_tick_count_select), .i_pe(i_parity_enable),
      .i_odd(i_parity_odd), .i_stb(i_stop_bits_select), .i_line(o_serial_out), .o_line(i_serial_in));
   initial forever #2 i_mclk = ~i_mclk;
   // Second base clock pulses every third cycle, so select 1 gives 6 cycles a tick
   always @(negedge i_mclk)
   begin
      ph = (ph + 1) % 3;
      i_base_ce[1] <= (ph == 0);
   end
   // Frame and abort pulses are counted, as they stand one cycle only
   always @(posedge i_mclk)
   begin
      ndone += o_rx_done;
      nab += o_rx_start_abort;
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      begin
         tests_run++;
         if (seen !== exp)
         begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d, mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // One frame in; error flags hold until the next frame
   task rx(input logic [7:0] d, input logic bp, input logic bs);
      int n0;
      begin
         n0 = ndone;
         i_peer.send(d, bp, bs);
         // The filter delays the vote of the last stop by up to its pass time
         for (i = 0; i < 40 && ndone == n0; i++) @(negedge i_mclk);
         check(ndone, n0 + 1);
         check(o_rx_data, d);
         check({o_rx_parity_err, o_rx_frame_err}, {bp, bs});
         check(o_rx_bit, !(bs && !i_stop_bits_select));
      end
   endtask
   // One frame out, bit widths measured by the peer
   task tx(input logic [7:0] d);
      begin
         i_tx_data = d;
         i_tx_start = 1'b1;
         fork
            i_peer.recv(rd, w1, w2);
            @(negedge i_mclk) i_tx_start = 1'b0;
         join
         for (i = 0; i < 9999 && o_tx_busy; i++) @(negedge i_mclk);
         check(o_tx_busy, 0);
         check(rd, d);
         check(w1, i_peer.tk(i_tick_count_select, 1) * cpt);
         check(w2, i_peer.tk(i_tick_count_select, 2) * cpt);
      end
   endtask
   initial
   begin
      repeat (5) @(negedge i_mclk);
      i_arst_n = 1'b1;
      repeat (3) @(negedge i_mclk);
      i_rx_enable = 1'b1;
      // Every tick-count code in both directions
      for (k = 0; k < 5; k++)
      begin
         i_tick_count_select = k;
         rx(8'h30 + k, 0, 0);
         tx(8'h5d);
      end
      // A start bit that is high at its votes is dropped, the next frame still lands
      k = nab;
      i_peer.glitch(6);
      repeat (60) @(negedge i_mclk);
      check(nab, k + 1);
      rx(8'hc3, 0, 0);
      // Odd parity with two stops, then even with one
      i_parity_enable = 1'b1;
      i_parity_odd = 1'b1;
      i_stop_bits_select = 1'b1;
      rx(8'h81, 0, 0);
      rx(8'h81, 1, 0);
      rx(8'h7e, 0, 1);
      tx(8'ha5);
      i_parity_odd = 1'b0;
      i_stop_bits_select = 1'b0;
      rx(8'h96, 1, 1);
      // Each filter setting: a pulse under the rejection time, then one over the pass time
      for (k = 1; k < 4; k++)
      begin
         i_rx_noise_filter_select = k;
         i_peer.glitch((1 << (k - 1)) * 2 - 1);
         repeat (30) @(negedge i_mclk);
         check(o_rx_busy, 0);
         i_peer.glitch((1 << k) * 2 + 1);
         for (i = 0; i < 60 && !o_rx_busy; i++) @(negedge i_mclk);
         check(o_rx_busy, 1);
         // Dropping the enable abandons the frame at once
         i_rx_enable = 1'b0;
         repeat (2) @(negedge i_mclk);
         check(o_rx_busy, 0);
         i_rx_enable = 1'b1;
         repeat (900) @(negedge i_mclk);
      end
      rx(8'h3c, 0, 0);
      // A start request with the transmitter disabled is ignored
      i_tx_enable = 1'b0;
      i_tx_start = 1'b1;
      @(negedge i_mclk) i_tx_start = 1'b0;
      check(o_tx_busy, 0);
      check(o_serial_out, 1);
      i_tx_enable = 1'b1;
      // Slower base clock through the second select
      i_rx_noise_filter_select = 2'h0;
      i_base_clock_select = 2'h1;
      cpt = 8'h06;
      tx(8'ha5);
      rx(8'he1, 0, 0);
      results;
   end
   // Hang guard
   initial
   begin
      repeat (90000) @(negedge i_mclk);
      num_errors++;
      results;
   end
endmodule // ubsf_core_bench
`default_nettype wire
